// file: rtl/rcdr_top.sv
// Calendar date register of the real-time clock with its register port.
//
// Overview of operation
// - Year tens digit lives in bits 31..28, values 0 to 9 only.
// - Year units digit lives in bits 27..24, values 0 to 9 only.
// - Month tens digit is the single bit 20, zero or one.
// - Month units digit lives in bits 19..16, values 0 to 9.
// - Day tens digit lives in bits 13..12, values 0 to 3.
// - Day units digit lives in bits 11..8, values 0 to 9.
// - Weekday lives in bits 2..0, values 0 to 6.
// - Date writes take effect only while the write-unlock bit is one.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module rcdr_top (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // Register port request.
    input wire rcdr_pkg::rcdr_req_t i_req,
    // Register port read data, valid the cycle after a read.
    output logic [rcdr_pkg::RCDR_DW-1:0] o_rdata,
    // Current date word and unlock state.
    output logic [rcdr_pkg::RCDR_DW-1:0] o_date,
    output logic o_unlock
);
    import rcdr_pkg::*;

    logic hit_date_w;
    logic hit_ctrl_w;
    logic date_wr_w;
    logic ctrl_wr_w;
    logic [31:0] ctrl_word_w;
    logic [31:0] date_w;
    logic [31:0] rd_sel_w;
    logic [31:0] rdata_nxt;
    logic [31:0] rdata_r;
    logic [3:0] fld_w [RCDR_NFLD];

    // Address decode.
    assign hit_date_w = (i_req.addr == RCDR_OFF_DATE);
    assign hit_ctrl_w = (i_req.addr == RCDR_OFF_CTRL);
    // A locked date write is dropped silently.
    assign date_wr_w = i_req.wr && hit_date_w && o_unlock;
    assign ctrl_wr_w = i_req.wr && hit_ctrl_w;

    rcdr_ctrl u_ctrl (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_wr(ctrl_wr_w),
        .i_wdata(i_req.wdata),
        .o_unlock(o_unlock),
        .o_word(ctrl_word_w)
    );

    // One digit register per field; each refuses values beyond its range.
    generate
        for (genvar g = 0; g < RCDR_NFLD; g++) begin : g_fld
            rcdr_digit #(
                .LSB(RCDR_FLD_LSB[g]),
                .WIDTH(RCDR_FLD_W[g]),
                .MAXV(RCDR_FLD_MAX[g])
            ) u_digit (
                .i_ref_clk(i_ref_clk),
                .i_nrst(i_nrst),
                .i_load(date_wr_w),
                .i_word(i_req.wdata),
                .o_value(fld_w[g])
            );
        end
    endgenerate

    // Date word assembly; unused bits are tied to zero.
    assign date_w = {fld_w[0], fld_w[1], 3'h0, fld_w[2][0], fld_w[3],
                     2'h0, fld_w[4][1:0], fld_w[5], 5'h0, fld_w[6][2:0]};
    assign o_date = date_w;

    // Read selection; an unmapped address reads zero.
    assign rd_sel_w = hit_date_w ? date_w : (hit_ctrl_w ? ctrl_word_w : 32'h0000_0000);
    assign rdata_nxt = i_req.rd ? rd_sel_w : 32'h0000_0000;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            rdata_r <= RCDR_RDATA_RST;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;

    // Checks.

    // High when every bounded digit of the written word lies inside its range.
    logic wr_legal_w;

    assign wr_legal_w = (i_req.wdata[31:28] <= 4'h9) && (i_req.wdata[27:24] <= 4'h9) &&
                        (i_req.wdata[19:16] <= 4'h9) && (i_req.wdata[11:8] <= 4'h9) &&
                        (i_req.wdata[2:0] <= 3'h6);

    sequence s_open_write;
        i_req.wr && hit_date_w && o_unlock;
    endsequence

    sequence s_locked_write;
        i_req.wr && hit_date_w && !o_unlock;
    endsequence

    sequence s_date_read;
        i_req.rd && hit_date_w;
    endsequence

    sequence s_ctrl_write;
        i_req.wr && hit_ctrl_w;
    endsequence

    sequence s_ctrl_read;
        i_req.rd && hit_ctrl_w;
    endsequence

    AST_YEAR_TENS_RANGE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_date[31:28] <= 4'h9
    ) else $error("Year tens digit out of range.");

    AST_YEAR_TENS_LOAD: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[31:28] <= 4'h9)) |=>
            (o_date[31:28] == $past(i_req.wdata[31:28]))
    ) else $error("Year tens digit not loaded.");

    AST_YEAR_TENS_REFUSE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[31:28] > 4'h9)) |=> $stable(o_date[31:28])
    ) else $error("Year tens digit took an illegal value.");

    AST_YEAR_UNITS_RANGE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_date[27:24] <= 4'h9
    ) else $error("Year units digit out of range.");

    AST_YEAR_UNITS_LOAD: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[27:24] <= 4'h9)) |=>
            (o_date[27:24] == $past(i_req.wdata[27:24]))
    ) else $error("Year units digit not loaded.");

    AST_MONTH_TENS_LOAD: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        s_open_write |=> (o_date[20] == $past(i_req.wdata[20]))
    ) else $error("Month tens digit not loaded.");

    AST_MONTH_UNITS_RANGE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_date[19:16] <= 4'h9
    ) else $error("Month units digit out of range.");

    AST_MONTH_UNITS_REFUSE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[19:16] > 4'h9)) |=> $stable(o_date[19:16])
    ) else $error("Month units digit took an illegal value.");

    AST_DAY_TENS_LOAD: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        s_open_write |=> (o_date[13:12] == $past(i_req.wdata[13:12]))
    ) else $error("Day tens digit not loaded.");

    AST_DAY_UNITS_RANGE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_date[11:8] <= 4'h9
    ) else $error("Day units digit out of range.");

    AST_DAY_UNITS_LOAD: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[11:8] <= 4'h9)) |=>
            (o_date[11:8] == $past(i_req.wdata[11:8]))
    ) else $error("Day units digit not loaded.");

    AST_WEEKDAY_RANGE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        o_date[2:0] <= 3'h6
    ) else $error("Weekday out of range.");

    AST_WEEKDAY_REFUSE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[2:0] == 3'h7)) |=> $stable(o_date[2:0])
    ) else $error("Weekday took an illegal value.");

    AST_OPEN_WRITE_WHOLE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 wr_legal_w) |=>
            (o_date == ($past(i_req.wdata) & RCDR_DATE_MASK))
    ) else $error("Unlocked legal date write not taken whole.");

    AST_UNLOCK_FOLLOWS_CTRL: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (i_req.wr && hit_ctrl_w) |=> (o_unlock == $past(i_req.wdata[RCDR_UNLOCK_BIT]))
    ) else $error("Unlock bit did not follow control write.");

    AST_DATE_CHANGES_ONLY_ON_OPEN: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !$stable(o_date) |-> $past(date_wr_w)
    ) else $error("Date changed without an unlocked write.");

    AST_RESERVED_ZERO: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (o_date & ~RCDR_DATE_MASK) == 32'h0000_0000
    ) else $error("Reserved date bits not zero.");

    AST_READ_DATE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        s_date_read |=> ((o_rdata == $past(o_date)) && ((o_rdata & ~RCDR_DATE_MASK) == 32'h0000_0000))
    ) else $error("Date read returned wrong data.");

    AST_LOCKED_WRITE_IGNORED: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        s_locked_write |=> ($stable(o_date) && $stable(o_unlock))
    ) else $error("Locked date write changed state.");

    AST_RDATA_ONE_CYCLE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        !i_req.rd |=> (o_rdata == 32'h0000_0000)
    ) else $error("Read data stood outside its cycle.");

    AST_YEAR_UNITS_REFUSE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[27:24] > 4'h9)) |=> $stable(o_date[27:24])
    ) else $error("Year units digit took an illegal value.");

    AST_MONTH_UNITS_LOAD: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[19:16] <= 4'h9)) |=>
            (o_date[19:16] == $past(i_req.wdata[19:16]))
    ) else $error("Month units digit not loaded.");

    AST_DAY_UNITS_REFUSE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[11:8] > 4'h9)) |=> $stable(o_date[11:8])
    ) else $error("Day units digit took an illegal value.");

    AST_WEEKDAY_LOAD: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[2:0] <= 3'h6)) |=>
            (o_date[2:0] == $past(i_req.wdata[2:0]))
    ) else $error("Weekday not loaded.");

    AST_WEEKDAY_TOP_VALUE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[2:0] == 3'h6)) |=> (o_date[2:0] == 3'h6)
    ) else $error("Weekday refused its largest legal value.");

    // Refusing one digit must not stop its neighbours from loading.
    AST_MONTH_TENS_BESIDE_REFUSAL: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[2:0] == 3'h7)) |=>
            (o_date[20] == $past(i_req.wdata[20]))
    ) else $error("Month tens digit lost beside a refused weekday.");

    AST_DAY_TENS_BESIDE_REFUSAL: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (s_open_write ##0 (i_req.wdata[31:28] > 4'h9)) |=>
            (o_date[13:12] == $past(i_req.wdata[13:12]))
    ) else $error("Day tens digit lost beside a refused year digit.");

    AST_UNLOCK_ONLY_ON_CTRL: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        $changed(o_unlock) |-> $past(ctrl_wr_w)
    ) else $error("Unlock bit changed without a control write.");

    AST_UNLOCK_THEN_WRITE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        ((s_ctrl_write ##0 i_req.wdata[RCDR_UNLOCK_BIT]) ##1 (i_req.wr && hit_date_w && wr_legal_w)) |=>
            (o_date == ($past(i_req.wdata) & RCDR_DATE_MASK))
    ) else $error("Date write right after unlock not taken.");

    AST_LOCK_THEN_WRITE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        ((s_ctrl_write ##0 !i_req.wdata[RCDR_UNLOCK_BIT]) ##1 (i_req.wr && hit_date_w)) |=>
            $stable(o_date)
    ) else $error("Date write right after lock changed the date.");

    AST_CTRL_WRITE_KEEPS_DATE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        s_ctrl_write |=> $stable(o_date)
    ) else $error("Control write changed the date.");

    AST_READ_CTRL: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        s_ctrl_read |=> (o_rdata == (32'($past(o_unlock)) << RCDR_UNLOCK_BIT))
    ) else $error("Control read returned wrong data.");

    AST_READ_UNMAPPED: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (i_req.rd && !hit_date_w && !hit_ctrl_w) |=> (o_rdata == 32'h0000_0000)
    ) else $error("Unmapped read returned nonzero data.");

    AST_UNMAPPED_WRITE_IGNORED: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        (i_req.wr && !hit_date_w && !hit_ctrl_w) |=> ($stable(o_date) && $stable(o_unlock))
    ) else $error("Unmapped write changed state.");

    AST_READ_KEEPS_STATE: assert property (
        @(posedge i_ref_clk) disable iff (!i_nrst)
        i_req.rd |=> ($stable(o_date) && $stable(o_unlock))
    ) else $error("Read changed state.");

endmodule

// file: rtl/rcdr_pkg.sv
// Constants and types shared by the calendar date register block.
package rcdr_pkg;

    // Register offsets on the plain register port.
    localparam int RCDR_AW = 8;
    localparam int RCDR_DW = 32;
    localparam logic [7:0] RCDR_OFF_DATE = 8'h00;
    localparam logic [7:0] RCDR_OFF_CTRL = 8'h04;

    // Position of the write-unlock bit in the clock control register.
    localparam int RCDR_UNLOCK_BIT = 3;

    // Values after reset.
    localparam logic RCDR_UNLOCK_RST = 1'b0;
    localparam logic [3:0] RCDR_DIGIT_RST = 4'h0;
    localparam logic [31:0] RCDR_RDATA_RST = 32'h0000_0000;

    // Bits of the date word that hold digits; all others read as zero.
    localparam logic [31:0] RCDR_DATE_MASK = 32'hff1f_3f07;

    // Digit fields: year tens, year units, month tens, month units,
    // day tens, day units, weekday.
    localparam int RCDR_NFLD = 7;
    localparam int RCDR_FLD_LSB [RCDR_NFLD] = '{28, 24, 20, 16, 12, 8, 0};
    localparam int RCDR_FLD_W [RCDR_NFLD] = '{4, 4, 1, 4, 2, 4, 3};
    localparam int RCDR_FLD_MAX [RCDR_NFLD] = '{9, 9, 1, 9, 3, 9, 6};

    // One request on the register port.
    typedef struct packed {
        logic [RCDR_AW-1:0] addr;
        logic [RCDR_DW-1:0] wdata;
        logic wr;
        logic rd;
    } rcdr_req_t;

endpackage

// file: rtl/rcdr_digit.sv
// One BCD digit field of the calendar date word.
`timescale 1ns/1ps
module rcdr_digit #(
    parameter int LSB = 0,
    parameter int WIDTH = 4,
    parameter int MAXV = 9
) (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // Load request and the whole written word.
    input wire logic i_load,
    input wire logic [31:0] i_word,
    // Held digit, zero above its width.
    output logic [3:0] o_value
);
    import rcdr_pkg::*;

    logic [3:0] cand_w;
    logic legal_w;

    assign cand_w = 4'(i_word[LSB +: WIDTH]);
    // A value beyond the digit's range is refused and the old digit stays.
    assign legal_w = (cand_w <= 4'(MAXV));

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_value <= RCDR_DIGIT_RST;
        end else if (i_load && legal_w) begin
            o_value <= cand_w;
        end
    end

endmodule

// file: rtl/rcdr_ctrl.sv
// Clock control register holding the write-unlock bit.
`timescale 1ns/1ps
module rcdr_ctrl (
    // Clock and reset.
    input wire logic i_ref_clk,
    input wire logic i_nrst,
    // Write of the control register.
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    // Unlock bit and the control word as read back.
    output logic o_unlock,
    output logic [31:0] o_word
);
    import rcdr_pkg::*;

    always_ff @(posedge i_ref_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_unlock <= RCDR_UNLOCK_RST;
        end else if (i_wr) begin
            o_unlock <= i_wdata[RCDR_UNLOCK_BIT];
        end
    end

    assign o_word = {{(31-RCDR_UNLOCK_BIT){1'b0}}, o_unlock, {RCDR_UNLOCK_BIT{1'b0}}};

endmodule

// file: sim/tb_rcdr_top.sv
// Self-checking testbench of the calendar date register block.
`timescale 1ns/1ps
module tb_rcdr_top;
    import rcdr_pkg::*;

    logic i_ref_clk = 1'b0;
    logic i_nrst = 1'b0;
    rcdr_req_t i_req = '0;
    logic [RCDR_DW-1:0] o_rdata;
    logic [RCDR_DW-1:0] o_date;
    logic o_unlock;
    logic [31:0] exp_date = 32'h0;
    logic exp_unlock = 1'b0;
    logic [31:0] seed = 32'h126658c2;
    logic [31:0] exp_q [$];
    logic rd_seen = 1'b0;
    logic [31:0] word;
    logic [7:0] addr;
    int miscompares = 0;
    int n_tests = 0;

    always #5 i_ref_clk = ~i_ref_clk;

    rcdr_top dut_u (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_req(i_req),
        .o_rdata(o_rdata),
        .o_date(o_date),
        .o_unlock(o_unlock)
    );

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] expv);
        n_tests++;
        if (seen !== expv) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expv);
        end
    endtask

    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // An unlocked date write loads each in-range digit and keeps any digit whose written value is out of range.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] m;
        logic [3:0] v;
        @(posedge i_ref_clk);
        i_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        if (a == RCDR_OFF_CTRL) exp_unlock = d[RCDR_UNLOCK_BIT];
        if (a == RCDR_OFF_DATE && exp_unlock) begin
            for (int f = 0; f < RCDR_NFLD; f++) begin
                m = (32'h1 << RCDR_FLD_W[f]) - 32'h1;
                v = 4'((d >> RCDR_FLD_LSB[f]) & m);
                if (v <= RCDR_FLD_MAX[f]) begin
                    exp_date = (exp_date & ~(m << RCDR_FLD_LSB[f])) | (32'(v) << RCDR_FLD_LSB[f]);
                end
            end
        end
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge i_ref_clk);
        i_req <= '{addr: a, wdata: seed, wr: 1'b0, rd: 1'b1};
        if (a == RCDR_OFF_DATE) exp_q.push_back(exp_date);
        else if (a == RCDR_OFF_CTRL) exp_q.push_back(32'(exp_unlock) << RCDR_UNLOCK_BIT);
        else exp_q.push_back(32'h0);
    endtask

    task automatic idle;
        @(posedge i_ref_clk);
        i_req <= '0;
        @(negedge i_ref_clk);
        check(o_date, exp_date);
        check(32'(o_unlock), 32'(exp_unlock));
    endtask

    // Read data are compared with the expected value in the cycle after the read strobe, and with zero in every other cycle after reset.
    always @(posedge i_ref_clk) rd_seen <= i_req.rd;

    always @(negedge i_ref_clk) begin
        if (rd_seen) begin
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("[ERR] t=%0t unexpected read seen=%h exp=%h", $time, o_rdata, 32'h0);
            end else begin
                check(o_rdata, exp_q.pop_front());
            end
        end else if (i_nrst) begin
            check(o_rdata, 32'h0);
        end
    end

    initial begin
        repeat (50000) @(posedge i_ref_clk);
        miscompares++;
        $display("[ERR] t=%0t timeout seen=%h exp=%h", $time, 32'h0, 32'h1);
        report_and_stop();
    end

    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        idle();
        rd(RCDR_OFF_DATE);
        rd(RCDR_OFF_CTRL);
        wr(RCDR_OFF_DATE, 32'h2912_3904);
        rd(RCDR_OFF_DATE);
        wr(RCDR_OFF_CTRL, 32'h0000_0008);
        wr(RCDR_OFF_DATE, 32'hffff_ffff);
        rd(RCDR_OFF_DATE);
        rd(RCDR_OFF_CTRL);
        idle();
        // Each digit in turn gets the first value above its range; for month tens and day tens that value lands above the field, which gets zero.
        for (int f = 0; f < RCDR_NFLD; f++) begin
            word = 32'h1111_1101 & ~(((32'h1 << RCDR_FLD_W[f]) - 32'h1) << RCDR_FLD_LSB[f]);
            word = word | (32'(RCDR_FLD_MAX[f] + 1) << RCDR_FLD_LSB[f]);
            wr(RCDR_OFF_DATE, 32'h2198_2305);
            wr(RCDR_OFF_DATE, word);
            rd(RCDR_OFF_DATE);
        end
        idle();
        // Random traffic mixes date, control and unmapped places back to back.
        for (int i = 0; i < 400; i++) begin
            seed = lfsr(seed);
            addr = seed[3] ? RCDR_OFF_DATE : (seed[2] ? RCDR_OFF_CTRL : {seed[7:4] | 4'h1, seed[11:8]});
            seed = lfsr(seed);
            if (seed[0]) wr(addr, seed);
            else rd(addr);
        end
        idle();
        // A second reset returns the date and the unlock bit to zero.
        @(posedge i_ref_clk);
        i_nrst <= 1'b0;
        exp_date = 32'h0;
        exp_unlock = 1'b0;
        repeat (2) @(posedge i_ref_clk);
        i_nrst <= 1'b1;
        idle();
        rd(RCDR_OFF_DATE);
        idle();
        // Let the read monitor finish its compare of this cycle before the run ends.
        @(posedge i_ref_clk);
        report_and_stop();
    end
endmodule
